// >>> inc/sem_host_defines.svh
`ifndef SEM_HOST_DEFINES_SVH
`define SEM_HOST_DEFINES_SVH

// Flag count and address width within semaphore space.
`define SEM_COUNT        8
`define SEM_ADDR_W       3
`define DATA_W           18
`define ADDR_W           19
// Access phase timing at 40 MHz (25 ns clock).
`define CLK_PERIOD_NS    25
`define SETUP_NS         25
`define STROBE_NS        50
`define HOLD_NS          25
`define SETUP_CYC        ((`SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_CYC       ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOLD_CYC         ((`HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W            4

`endif

// >>> inc/sem_host_pkg.sv
package sem_host_pkg;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_SETUP = 5'b00010,
    ST_STRB  = 5'b00100,
    ST_HOLD  = 5'b01000,
    ST_INIT  = 5'b10000
  } state_t;

  typedef enum logic [1:0] {
    OP_CLAIM   = 2'h0,
    OP_RELEASE = 2'h1,
    OP_POLL    = 2'h2
  } op_t;

  // Pins of one port of the dual-port part, as the host drives them.
  typedef struct packed {
    logic        semaphore_select_n;
    logic        chip_enable_low_active;
    logic        chip_enable_high_active;
    logic        rw_n;
    logic        oe_n;
    logic [1:0]  lower_upper_byte_enables;
    logic [18:0] addr;
  } port_ctl_t;

endpackage

// >>> rtl/sem_host.sv
`timescale 1ns/1ps
`include "sem_host_defines.svh"
// Operation
// - Select low, then ordinary SRAM access.
// - Claim by write zero, then read back.
// - Failed claim: poll or withdraw request.
// - Software writes one everywhere at power-up.
// - Semaphore access: low enable high, high enable low.
module sem_host (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        req_valid,
  input  wire sem_host_pkg::op_t           req_op,
  input  wire logic [`SEM_ADDR_W-1:0]      req_flag,
  output logic                             req_ready,
  output logic                             rsp_valid,
  output logic                             rsp_granted,
  output logic                             init_done,
  output sem_host_pkg::port_ctl_t          port_ctl,
  output logic [`DATA_W-1:0]               data_o,
  output logic                             data_oe_n,
  input  wire logic [`DATA_W-1:0]          data_i
);

  sem_host_pkg::state_t       state_ff;
  sem_host_pkg::op_t          op_ff;
  logic [`SEM_ADDR_W-1:0]     flag_ff;
  logic [`CNT_W-1:0]          cnt_ff;
  logic                       is_write_ff;
  logic                       init_side_ff;
  logic [`DATA_W-1:0]         data_s1_ff;
  logic [`DATA_W-1:0]         data_s2_ff;
  logic                       rsp_valid_ff;
  logic                       rsp_granted_ff;
  logic                       init_done_ff;

  function automatic logic [`CNT_W-1:0] cyc(input int n);
    cyc = n[`CNT_W-1:0] - 4'h1;
  endfunction

  // The data pins come from another timing domain.
  always_ff @(posedge clk) begin
    data_s1_ff <= data_i;
    data_s2_ff <= data_s1_ff;
  end

  // Requests are only accepted after the power-up release pass.
  assign req_ready = (state_ff == sem_host_pkg::ST_IDLE) && init_done_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff     <= sem_host_pkg::ST_INIT;
      op_ff        <= sem_host_pkg::OP_RELEASE;
      flag_ff      <= 3'h0;
      cnt_ff       <= 4'h0;
      is_write_ff  <= 1'b1;
      init_side_ff <= 1'b0;
      init_done_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        sem_host_pkg::ST_INIT: begin
          // Every flag is released before use since the device has no reset.
          op_ff        <= sem_host_pkg::OP_RELEASE;
          is_write_ff  <= 1'b1;
          init_side_ff <= 1'b1;
          cnt_ff       <= cyc(`SETUP_CYC);
          state_ff     <= sem_host_pkg::ST_SETUP;
        end
        sem_host_pkg::ST_IDLE: begin
          if (req_valid && req_ready) begin
            op_ff       <= req_op;
            flag_ff     <= req_flag;
            // A claim writes zero first; the read-back follows automatically.
            is_write_ff <= (req_op != sem_host_pkg::OP_POLL);
            cnt_ff      <= cyc(`SETUP_CYC);
            state_ff    <= sem_host_pkg::ST_SETUP;
          end
        end
        sem_host_pkg::ST_SETUP: begin
          if (cnt_ff == 4'h0) begin
            cnt_ff   <= cyc(`STROBE_CYC);
            state_ff <= sem_host_pkg::ST_STRB;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        sem_host_pkg::ST_STRB: begin
          // Fixed strobe length: the device never adds wait states.
          if (cnt_ff == 4'h0) begin
            cnt_ff   <= cyc(`HOLD_CYC);
            state_ff <= sem_host_pkg::ST_HOLD;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        sem_host_pkg::ST_HOLD: begin
          if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
          end else if (op_ff == sem_host_pkg::OP_CLAIM && is_write_ff) begin
            is_write_ff <= 1'b0;
            cnt_ff      <= cyc(`SETUP_CYC);
            state_ff    <= sem_host_pkg::ST_SETUP;
          end else if (init_side_ff && flag_ff != 3'h7) begin
            flag_ff  <= flag_ff + 3'h1;
            cnt_ff   <= cyc(`SETUP_CYC);
            state_ff <= sem_host_pkg::ST_SETUP;
          end else begin
            init_side_ff <= 1'b0;
            init_done_ff <= 1'b1;
            flag_ff      <= 3'h0;
            state_ff     <= sem_host_pkg::ST_IDLE;
          end
        end
        default: begin
          state_ff <= sem_host_pkg::ST_INIT;
        end
      endcase
    end
  end

  // Read result taken at the end of hold, two sync stages after output enable fell.
  always_ff @(posedge clk) begin
    if (rst) begin
      rsp_valid_ff   <= 1'b0;
      rsp_granted_ff <= 1'b0;
    end else begin
      rsp_valid_ff <= 1'b0;
      if (state_ff == sem_host_pkg::ST_HOLD && cnt_ff == 4'h0 && !init_side_ff &&
          !(op_ff == sem_host_pkg::OP_CLAIM && is_write_ff)) begin
        rsp_valid_ff <= 1'b1;
        // Release answers granted low; reads own the token only on all zeros.
        rsp_granted_ff <= !is_write_ff && (data_s2_ff == 18'h00000);
      end
    end
  end

  assign rsp_valid   = rsp_valid_ff;
  assign rsp_granted = rsp_granted_ff;
  assign init_done   = init_done_ff;

  // Pin drive. Outside an access every select is inactive for standby.
  always_ff @(posedge clk) begin
    if (rst) begin
      port_ctl  <= '{semaphore_select_n: 1'b1, chip_enable_low_active: 1'b1,
                     chip_enable_high_active: 1'b0, rw_n: 1'b1, oe_n: 1'b1,
                     lower_upper_byte_enables: 2'h3, addr: 19'h00000};
      data_o    <= 18'h00000;
      data_oe_n <= 1'b1;
    end else begin
      port_ctl.chip_enable_low_active  <= 1'b1;
      port_ctl.chip_enable_high_active <= 1'b0;
      port_ctl.addr <= {16'h0000, flag_ff};
      if (state_ff == sem_host_pkg::ST_IDLE || state_ff == sem_host_pkg::ST_INIT) begin
        port_ctl.semaphore_select_n       <= 1'b1;
        port_ctl.lower_upper_byte_enables <= 2'h3;
        port_ctl.rw_n <= 1'b1;
        port_ctl.oe_n <= 1'b1;
        data_oe_n     <= 1'b1;
      end else begin
        port_ctl.semaphore_select_n       <= 1'b0;
        port_ctl.lower_upper_byte_enables <= 2'h0;
        port_ctl.rw_n <= !(is_write_ff && state_ff == sem_host_pkg::ST_STRB);
        // Output enable falls at the start of each read phase, with the select only for a poll, so the bus is settled before the sync flops take it.
        port_ctl.oe_n <= is_write_ff;
        data_oe_n     <= !is_write_ff;
        // Zero requests, one releases; only bit zero carries meaning.
        data_o <= {17'h00000, op_ff != sem_host_pkg::OP_CLAIM};
      end
    end
  end

  // Device-side arbitration ..is outside this host.
  a_idle_deselect: assert property (@(posedge clk) disable iff (rst)
    state_ff == sem_host_pkg::ST_IDLE |=> port_ctl.semaphore_select_n)
    else $error("select active while idle");
  a_ce_levels: assert property (@(posedge clk) disable iff (rst)
    !port_ctl.semaphore_select_n |-> port_ctl.chip_enable_low_active && !port_ctl.chip_enable_high_active)
    else $error("chip enables wrong during semaphore access");
  a_claim_data: assert property (@(posedge clk) disable iff (rst)
    !data_oe_n && op_ff == sem_host_pkg::OP_CLAIM && !init_side_ff |-> data_o[0] == 1'b0)
    else $error("claim does not write zero");
  a_claim_readback: assert property (@(posedge clk) disable iff (rst)
    $fell(port_ctl.rw_n) && op_ff == sem_host_pkg::OP_CLAIM |-> ##[1:12] !port_ctl.oe_n)
    else $error("claim write not followed by read");
  a_no_read_write: assert property (@(posedge clk) disable iff (rst)
    !port_ctl.oe_n |-> port_ctl.rw_n && data_oe_n)
    else $error("read and write overlap");
  a_addr_low: assert property (@(posedge clk) disable iff (rst)
    port_ctl.addr[18:3] == 16'h0000)
    else $error("high address lines driven");
  a_strobe_len: assert property (@(posedge clk) disable iff (rst)
    $fell(port_ctl.rw_n) |-> !port_ctl.rw_n [*2] ##1 port_ctl.rw_n)
    else $error("write strobe length wrong");
  a_init_release: assert property (@(posedge clk) disable iff (rst)
    !init_done_ff && !data_oe_n |-> data_o[0])
    else $error("init writes not one");

endmodule

// >>> tb/sem_dev_model.sv
`timescale 1ns/1ps
// Both ports of the semaphore space; port one faces the host, port two is driven by the bench.
module sem_dev_model (
  input  wire sem_host_pkg::port_ctl_t ctl,
  input  wire logic [17:0]             d_host,
  input  wire logic                    d_host_oe_n,
  output logic [17:0]                  d_bus,
  input  wire logic                    b_wr,
  input  wire logic [2:0]              b_flag,
  input  wire logic                    b_val,
  output logic [7:0]                   b_view
);
  logic [7:0]  req_a;
  logic [7:0]  req_b;
  logic [1:0]  own [8];
  logic        rd_q;
  logic        armed;
  logic [17:0] last;
  wire sel = !ctl.semaphore_select_n && ctl.chip_enable_low_active && !ctl.chip_enable_high_active;
  wire wr_on = sel && !ctl.rw_n && ctl.lower_upper_byte_enables != 2'h3;
  wire rd_on = sel && ctl.rw_n && !ctl.oe_n && ctl.lower_upper_byte_enables != 2'h3;
  initial begin
    req_a = 'x;
    req_b = 'x;
    armed = 1'b0;
    last = '0;
    foreach (own[i]) own[i] = 2'h0;
  end
  // A write to a flag that the other side owns only reaches the writer's own request latch.
  task automatic put(input int s, input logic [2:0] f, input logic v);
    if (s == 1) req_a[f] = v;
    else req_b[f] = v;
    if (own[f] == s && v) own[f] = ((s == 1) ? req_b[f] : req_a[f]) === 1'b0 ? 2'(3 - s) : 2'h0;
    else if (own[f] == 2'h0 && !v) own[f] = 2'(s);
  endtask
  // There is no busy or wait path: a write completes when its strobe ends.
  always @(posedge wr_on) armed = 1'b1;
  always @(negedge wr_on) begin
    if (armed) put(1, ctl.addr[2:0], d_host[0]);
    armed = 1'b0;
  end
  always @(posedge b_wr) put(2, b_flag, b_val);
  always @(posedge rd_on) rd_q = (own[ctl.addr[2:0]] != 2'h1);
  // An undriven bus shows the inverse of its last value so a stale read cannot pass.
  always @(rd_on, rd_q, d_host, d_host_oe_n) begin
    if (rd_on || !d_host_oe_n) last = rd_on ? {18{rd_q}} : d_host;
  end
  assign d_bus = rd_on ? {18{rd_q}} : (!d_host_oe_n ? d_host : ~last);
  always_comb begin
    foreach (own[i]) b_view[i] = (own[i] != 2'h2);
  end
endmodule

// >>> tb/sem_host_tb_top.sv
`timescale 1ns/1ps
module sem_host_tb_top;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    req_valid = 1'b0;
  logic                    b_wr = 1'b0;
  logic                    b_val = 1'b1;
  logic [2:0]              req_flag = 3'h0;
  logic [2:0]              b_flag = 3'h0;
  sem_host_pkg::op_t       req_op = sem_host_pkg::OP_POLL;
  logic                    req_ready, rsp_valid, rsp_granted, init_done, data_oe_n;
  sem_host_pkg::port_ctl_t port_ctl;
  logic [17:0]             data_o, data_i;
  logic [7:0]              b_view;
  int                      num_errors = 0;
  int                      check_count = 0;
  always #12.5 clk = ~clk;
  sem_host dut_u (.clk(clk), .rst(rst), .req_valid(req_valid), .req_op(req_op), .req_flag(req_flag),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_granted(rsp_granted), .init_done(init_done),
    .port_ctl(port_ctl), .data_o(data_o), .data_oe_n(data_oe_n), .data_i(data_i));
  sem_dev_model dev_u (.ctl(port_ctl), .d_host(data_o), .d_host_oe_n(data_oe_n), .d_bus(data_i),
    .b_wr(b_wr), .b_flag(b_flag), .b_val(b_val), .b_view(b_view));
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic op(input sem_host_pkg::op_t o, input logic [2:0] f, input int lat, input logic g);
    int         n;
    logic [7:0] pins;
    n = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    req_op = o;
    req_flag = f;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    n = 1;
    while (rsp_valid !== 1'b1 && n < 20) begin
      pins = {1'b0, port_ctl.chip_enable_low_active, port_ctl.chip_enable_high_active,
              port_ctl.lower_upper_byte_enables, port_ctl.addr[2:0]};
      if (!port_ctl.semaphore_select_n) check("pins", {5'h08, f}, pins);
      @(negedge clk);
      n++;
    end
    check("latency", 8'(lat), 8'(n));
    check("grant", {7'h0, g}, {7'h0, rsp_granted});
  endtask
  task automatic b_write(input logic [2:0] f, input logic v);
    @(negedge clk);
    b_flag = f;
    b_val = v;
    b_wr = 1'b1;
    @(negedge clk);
    b_wr = 1'b0;
  endtask
  task automatic t_init();
    int n;
    n = 0;
    // The far side releases its own request latches as well.
    for (int f = 0; f < 8; f++) b_write(3'(f), 1'b1);
    while (init_done !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    check("init", 8'h01, {7'h0, init_done});
    $display("test init finished");
  endtask
  task automatic t_all();
    for (int f = 0; f < 8; f++) begin
      op(sem_host_pkg::OP_CLAIM, 3'(f), 9, 1'b1);
      check("other side", 8'hFF, b_view);
      op(sem_host_pkg::OP_RELEASE, 3'(f), 5, 1'b0);
      check("freed", 8'hFF, b_view);
    end
    $display("test all flags finished");
  endtask
  task automatic t_pass();
    op(sem_host_pkg::OP_CLAIM, 3'h3, 9, 1'b1);
    b_write(3'h3, 1'b0);
    op(sem_host_pkg::OP_POLL, 3'h3, 5, 1'b1);
    check("pending", 8'hFF, b_view);
    op(sem_host_pkg::OP_RELEASE, 3'h3, 5, 1'b0);
    check("handover", 8'hF7, b_view);
    op(sem_host_pkg::OP_CLAIM, 3'h3, 9, 1'b0);
    op(sem_host_pkg::OP_POLL, 3'h3, 5, 1'b0);
    b_write(3'h3, 1'b1);
    op(sem_host_pkg::OP_POLL, 3'h3, 5, 1'b1);
    op(sem_host_pkg::OP_RELEASE, 3'h3, 5, 1'b0);
    check("free again", 8'hFF, b_view);
    $display("test token passing finished");
  endtask
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_init();
    t_all();
    t_pass();
    stop_test();
  end
  // Whole run is some 220 cycles; the limit leaves ample margin.
  initial begin
    #100000;
    num_errors++;
    stop_test();
  end
endmodule
